//--- shared/lbsc_pkg.sv
// Constants, field layouts and carrier types for the LED backlight sink control bank
// Function
// RL1: Current register at 0x86 and 0xA086
// RL2: Control at 0x87/0xA087, bit1 selects frequency
// RL3: Both registers eight bits, written whole
// RL4: Bits 4:0 hold sink current code
// RL5: Code zero still gives one step current
// RL6: Bit 6 selects full or half range
// RL7: Bit 7 local enable; bit 5 reserved
// RL8: Ramp one code step per 32 us
// RL9: Gate on at most 94 percent
// RL10: Run only when global and local enabled
// RL11: Defaults load only at power-on reset
// RL12: New codes ignored while ramp runs
// RL13: Reads return stored bits; ctrl 5:4 read-only
// RL14: Host writes code with enable changes
package lbsc_pkg;
   // Register map
   localparam logic [7:0]  REG_PAGE0         = 8'h00;
   localparam logic [7:0]  OUT_CUR_ADDR      = 8'h86;
   localparam logic [7:0]  CTRL_ADDR         = 8'h87;
   localparam logic [15:0] MCU_OUT_CUR_ADDR  = 16'ha086;
   localparam logic [15:0] MCU_CTRL_ADDR     = 16'ha087;
   // Field positions
   localparam int          CODE_W            = 5;
   localparam int          RSVD_BIT          = 5;
   localparam int          RANGE_BIT         = 6;
   localparam int          ENABLE_BIT        = 7;
   localparam int          FREQ_BIT          = 1;
   localparam logic [7:0]  CTRL_RO_MASK      = 8'h30;
   // Reset values
   localparam logic [7:0]  OUT_CUR_RST       = 8'h40;
   localparam logic [7:0]  CTRL_RST          = 8'h02;
   // Timing
   localparam int          CLK_MHZ           = 100;
   localparam int          SLEW_STEP_US      = 32;
   localparam int          SLEW_STEP_CYCLES  = SLEW_STEP_US * CLK_MHZ;
   localparam int          FAST_KHZ          = 1000;
   localparam int          SLOW_KHZ          = 500;
   localparam int          PERIOD_FAST       = CLK_MHZ * 1000 / FAST_KHZ;
   localparam int          PERIOD_SLOW       = CLK_MHZ * 1000 / SLOW_KHZ;
   localparam int          MAX_DUTY_PCT      = 94;
   // Output-current register layout
   typedef struct packed {
      logic              enable;
      logic              range;
      logic              rsvd;
      logic [CODE_W-1:0] code;
   } lbsc_cur_s;
   // Host (I2C side) request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lbsc_host_req_s;
   // Microcontroller request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } lbsc_mcu_req_s;
   // Read answer
   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [7:0] data;
   } lbsc_rsp_s;
endpackage

//--- verilog/lbsc_slew.sv
// Sink-current slew ramp: walks the level one code step per interval
module lbsc_slew #(
   parameter int CODE_W      = 5,
   parameter int STEP_CYCLES = 3200
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // Target and ramped level
   input  wire logic [CODE_W-1:0] target,
   output logic      [CODE_W-1:0] level,
   output logic                   busy
);
   localparam int CNT_W = $clog2(STEP_CYCLES + 1);

   typedef enum logic [1:0] {
      LBSC_SL_IDLE = 2'b01,
      LBSC_SL_RAMP = 2'b10
   } lbsc_slew_e;

   lbsc_slew_e       state;
   logic [CNT_W-1:0] tick;
   logic             final_step;

   initial begin
      if (STEP_CYCLES < 1 || CODE_W < 1) $error("lbsc_slew: bad parameters");
   end

   // Last-step test; the direction guard keeps +1/-1 from wrapping at the code ends
   always_comb begin
      if (target > level) final_step = (target == level + 1'b1);
      else if (target < level) final_step = (target == level - 1'b1);
      else final_step = 1'b1;
   end

   // Step timer and state; level moves only when the interval expires
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= LBSC_SL_IDLE;
         tick  <= '0;
         level <= '0;
      end else begin
         unique case (state)
            LBSC_SL_IDLE: begin
               tick <= '0;
               if (target != level) state <= LBSC_SL_RAMP;
            end
            LBSC_SL_RAMP: begin
               if (tick == CNT_W'(STEP_CYCLES - 1)) begin // [RL8]
                  tick <= '0;
                  if (target > level) level <= level + 1'b1;
                  else if (target < level) level <= level - 1'b1;
                  if (final_step) begin
                     state <= LBSC_SL_IDLE;
                  end
               end else begin
                  tick <= tick + 1'b1;
               end
            end
         endcase
      end
   end

   // Busy stays a flop so that the bank's write filter sees a clean level
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) busy <= 1'b0;
      else busy <= (state == LBSC_SL_RAMP) ? !(tick == CNT_W'(STEP_CYCLES - 1) && final_step)
                                           : (target != level); // [RL12]
   end
endmodule // lbsc_slew

//--- verilog/lbsc_gate_pwm.sv
// Boost gate drive with period from frequency select and a hard duty ceiling
module lbsc_gate_pwm #(
   parameter int PERIOD_FAST = 100,
   parameter int PERIOD_SLOW = 200,
   parameter int MAX_PCT     = 94
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Control
   input  wire logic       run,
   input  wire logic       fast_sel,
   input  wire logic [7:0] duty_req,
   // Gate
   output logic            gate
);
   localparam logic [7:0] LIM_FAST = 8'(PERIOD_FAST * MAX_PCT / 100);
   localparam logic [7:0] LIM_SLOW = 8'(PERIOD_SLOW * MAX_PCT / 100);

   logic [7:0] phase;
   logic [7:0] last;
   logic [7:0] limit;
   logic [7:0] on_time;

   initial begin
      if (PERIOD_SLOW > 256 || PERIOD_FAST > 256 || MAX_PCT > 100 || PERIOD_FAST < 2)
         $error("lbsc_gate_pwm: bad parameters");
   end

   // Period end and on-time clamp; rounding down keeps the ceiling strict
   always_comb begin
      last    = fast_sel ? 8'(PERIOD_FAST - 1) : 8'(PERIOD_SLOW - 1);
      limit   = fast_sel ? LIM_FAST : LIM_SLOW;
      on_time = (duty_req > limit) ? limit : duty_req; // [RL9]
   end

   // Phase counter restarts whenever the converter is off
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) phase <= '0;
      else if (!run || phase >= last) phase <= '0;
      else phase <= phase + 1'b1;
   end

   // Gate high for the first on_time cycles of each period
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) gate <= 1'b0;
      else gate <= run && (phase < on_time); // [RL9] [RL10]
   end
endmodule // lbsc_gate_pwm

//--- verilog/lbsc_top.sv
// LED backlight sink control register bank with slew ramp and gate drive
module lbsc_top #(
   parameter int SLEW_CYCLES = lbsc_pkg::SLEW_STEP_CYCLES
) (
   // Clock and power-on reset
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   // Host register port (page-0 byte addresses)
   input  wire lbsc_pkg::lbsc_host_req_s host_req,
   output lbsc_pkg::lbsc_rsp_s           host_rsp,
   // Microcontroller register port
   input  wire lbsc_pkg::lbsc_mcu_req_s  mcu_req,
   output lbsc_pkg::lbsc_rsp_s           mcu_rsp,
   // System
   input  wire logic                    global_enable,
   input  wire logic [7:0]              duty_request,
   // Converter side
   output logic                         converter_on,
   output logic                         current_range_select,
   output logic [lbsc_pkg::CODE_W-1:0]  sink_current_level,
   output logic                         switching_frequency_select,
   output logic                         slew_busy,
   output logic                         boost_gate
);
   import lbsc_pkg::*;

   lbsc_cur_s  led_sink_current_setting;
   logic [7:0] led_converter_control;
   logic [1:0] host_sel;
   logic [1:0] mcu_sel;
   logic [1:0] wr_sel;
   logic [7:0] wr_data;
   logic       wr_any;
   lbsc_cur_s  next_setting;
   logic       ramp_busy;

   initial begin
      if (SLEW_CYCLES < 1) $error("lbsc_top: SLEW_CYCLES must be at least 1");
   end

   // One-hot register select: bit0 output-current, bit1 control
   function automatic logic [1:0] dec_host(input logic [7:0] page, input logic [7:0] addr);
      dec_host = 2'b00;
      if (page == REG_PAGE0 && addr == OUT_CUR_ADDR) dec_host = 2'b01; // [RL1]
      if (page == REG_PAGE0 && addr == CTRL_ADDR) dec_host = 2'b10;    // [RL2]
   endfunction

   function automatic logic [1:0] dec_mcu(input logic [15:0] addr);
      dec_mcu = 2'b00;
      if (addr == MCU_OUT_CUR_ADDR) dec_mcu = 2'b01; // [RL1]
      if (addr == MCU_CTRL_ADDR) dec_mcu = 2'b10;    // [RL2]
   endfunction

   function automatic logic [7:0] rd_mux(input logic [1:0] sel, input lbsc_cur_s cur,
                                         input logic [7:0] ctrl);
      rd_mux = 8'h00;
      if (sel[0]) rd_mux = cur;                  // [RL13]
      if (sel[1]) rd_mux = ctrl & ~CTRL_RO_MASK; // [RL13]
   endfunction

   // Write arbitration: a same-cycle host write to a mapped register wins over the microcontroller
   always_comb begin
      host_sel = dec_host(host_req.page, host_req.addr);
      mcu_sel  = dec_mcu(mcu_req.addr);
      if (host_req.wr && host_sel != 2'b00) begin
         wr_sel  = host_sel;
         wr_data = host_req.wdata;
      end else if (mcu_req.wr) begin
         wr_sel  = mcu_sel;
         wr_data = mcu_req.wdata;
      end else begin
         wr_sel  = 2'b00;
         wr_data = 8'h00;
      end
      wr_any = wr_sel != 2'b00;
   end

   // Whole-byte update; the code field is frozen while the ramp runs
   always_comb begin
      next_setting = lbsc_cur_s'(wr_data); // [RL3] [RL4] [RL6] [RL7]
      if (ramp_busy) next_setting.code = led_sink_current_setting.code; // [RL12]
   end

   // Output-current register; defaults only at power-on reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) led_sink_current_setting <= lbsc_cur_s'(OUT_CUR_RST); // [RL11]
      else if (wr_any && wr_sel[0]) led_sink_current_setting <= next_setting; // [RL3]
   end

   // Control register; read-only bits never store a write
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) led_converter_control <= CTRL_RST; // [RL11]
      else if (wr_any && wr_sel[1]) led_converter_control <= wr_data & ~CTRL_RO_MASK; // [RL13] [RL3]
   end

   // Host read answer, one cycle after the request
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         host_rsp <= '0;
      end else begin
         host_rsp.valid <= host_req.rd;
         host_rsp.hit   <= host_req.rd && host_sel != 2'b00;
         host_rsp.data  <= host_req.rd ? rd_mux(host_sel, led_sink_current_setting,
                                                led_converter_control) : 8'h00;
      end
   end

   // Microcontroller read answer, one cycle after the request
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mcu_rsp <= '0;
      end else begin
         mcu_rsp.valid <= mcu_req.rd;
         mcu_rsp.hit   <= mcu_req.rd && mcu_sel != 2'b00;
         mcu_rsp.data  <= mcu_req.rd ? rd_mux(mcu_sel, led_sink_current_setting,
                                              led_converter_control) : 8'h00;
      end
   end

   // Converter run state; clearing an enable keeps the stored settings
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) converter_on <= 1'b0; // [RL11]
      else converter_on <= global_enable && led_sink_current_setting.enable; // [RL10]
   end

   // Range and frequency pass out through flops; the code offset is analog
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         current_range_select       <= OUT_CUR_RST[RANGE_BIT];
         switching_frequency_select <= CTRL_RST[FREQ_BIT];
      end else begin
         current_range_select       <= led_sink_current_setting.range; // [RL6] [RL5]
         switching_frequency_select <= led_converter_control[FREQ_BIT]; // [RL2]
      end
   end

   // Slew ramp toward the stored code
   lbsc_slew #(
      .CODE_W      (CODE_W),
      .STEP_CYCLES (SLEW_CYCLES)
   ) u_slew (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .target  (led_sink_current_setting.code), // [RL8]
      .level   (sink_current_level),
      .busy    (ramp_busy)
   );

   // Busy mirror for the outside, one cycle behind the internal filter
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) slew_busy <= 1'b0;
      else slew_busy <= ramp_busy;
   end

   // Gate drive, only while the converter runs
   lbsc_gate_pwm #(
      .PERIOD_FAST (PERIOD_FAST),
      .PERIOD_SLOW (PERIOD_SLOW),
      .MAX_PCT     (MAX_DUTY_PCT)
   ) u_gate (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .run      (converter_on), // [RL10]
      .fast_sel (switching_frequency_select),
      .duty_req (duty_request),
      .gate     (boost_gate)
   );
endmodule // lbsc_top

//--- dv/lbsc_monitor.sv
// Port checker for the LED sink control bank, bound to the top
module lbsc_checker
   import lbsc_pkg::*;
#(
   parameter int SLEW_CYCLES = 8
) (
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    resetn,
   // Register ports
   input wire lbsc_pkg::lbsc_host_req_s host_req,
   input wire lbsc_pkg::lbsc_mcu_req_s  mcu_req,
   input wire lbsc_pkg::lbsc_rsp_s      mcu_rsp,
   // System and converter side
   input wire logic                    global_enable,
   input wire logic                    converter_on,
   input wire logic                    current_range_select,
   input wire logic [CODE_W-1:0]       sink_current_level,
   input wire logic                    switching_frequency_select,
   input wire logic                    slew_busy,
   input wire logic                    boost_gate
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   int                hi_cnt;
   int                since;
   logic [CODE_W-1:0] lvl_q;
   // Length of the current gate-high run
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) hi_cnt <= 0;
      else hi_cnt <= boost_gate ? hi_cnt + 1 : 0;
   end
   // Cycles since the last ramp step; saturates so long idle spans stay cheap
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lvl_q <= '0;
         since <= SLEW_CYCLES;
      end else begin
         lvl_q <= sink_current_level;
         since <= (sink_current_level != lvl_q) ? 0 : (since < SLEW_CYCLES ? since + 1 : since);
      end
   end
   a_conv_off: assert property (!global_enable |=> !converter_on)
      else $error("converter on without global enable");
   a_gate_off: assert property (!converter_on && $past(!converter_on) |-> !boost_gate)
      else $error("gate driven while converter off");
   a_duty_cap: assert property (hi_cnt <= (switching_frequency_select ? 94 : 188))
      else $error("gate on-time above ceiling");
   a_step_one: assert property (sink_current_level != lvl_q |->
      (sink_current_level == lvl_q + 5'h01 || sink_current_level == lvl_q - 5'h01))
      else $error("level moved by more than one step");
   a_slew_space: assert property (sink_current_level != lvl_q |-> since >= SLEW_CYCLES - 1)
      else $error("ramp steps too close");
   a_ctrl_ro: assert property (mcu_req.rd && mcu_req.addr == MCU_CTRL_ADDR |=> mcu_rsp.data[5:4] == 2'b00)
      else $error("read-only control bits not zero");
   a_range_follow: assert property (host_req.wr && host_req.page == REG_PAGE0 && host_req.addr == OUT_CUR_ADDR
      |=> ##1 current_range_select == $past(host_req.wdata[6], 2))
      else $error("range output does not follow write");
   a_freq_follow: assert property (mcu_req.wr && mcu_req.addr == MCU_CTRL_ADDR && !host_req.wr
      |=> ##1 switching_frequency_select == $past(mcu_req.wdata[1], 2))
      else $error("frequency output does not follow write");
   c_ramp: cover property ($rose(slew_busy));
   c_gate: cover property ($rose(boost_gate));
   c_on: cover property ($rose(converter_on));
endmodule // lbsc_checker

bind lbsc_top lbsc_checker #(.SLEW_CYCLES(SLEW_CYCLES)) lbsc_checker_i (.ref_clk, .resetn, .host_req, .mcu_req,
   .mcu_rsp, .global_enable, .converter_on, .current_range_select, .sink_current_level,
   .switching_frequency_select, .slew_busy, .boost_gate);

//--- dv/lbsc_host_model.sv
// Controlling-party model: whole-byte accesses on the host or mcu port
module lbsc_host_model (
   // Clock
   input wire logic                    ref_clk,
   // Requests out, answers in
   output lbsc_pkg::lbsc_host_req_s     host_req,
   input wire lbsc_pkg::lbsc_rsp_s      host_rsp,
   output lbsc_pkg::lbsc_mcu_req_s      mcu_req,
   input wire lbsc_pkg::lbsc_rsp_s      mcu_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   import lbsc_pkg::*;
   initial begin
      host_req = '0;
      mcu_req = '0;
   end
   // One access; a[15] picks the mcu port, else a is page and offset
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic h);
      @(posedge ref_clk);
      #1;
      if (a[15]) mcu_req = '{wr, !wr, a, d};
      else host_req = '{wr, !wr, a[15:8], a[7:0], d};
      @(posedge ref_clk);
      #1;
      // Released lines flip so a stale value is never mistaken for a live one
      host_req = {2'b00, ~host_req[23:0]};
      mcu_req = {2'b00, ~mcu_req[23:0]};
      q = a[15] ? mcu_rsp.data : host_rsp.data;
      h = a[15] ? (mcu_rsp.hit & mcu_rsp.valid) : (host_rsp.hit & host_rsp.valid);
   endtask
endmodule // lbsc_host_model

//--- dv/led_backlight_sink_control_bench.sv
// Self-checking bench for the LED sink control register bank
module led_backlight_sink_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import lbsc_pkg::*;
   localparam int SC = 8;
   logic              ref_clk, resetn, global_enable, h;
   logic              converter_on, current_range_select, switching_frequency_select, slew_busy, boost_gate;
   logic [7:0]        duty_request, q;
   logic [CODE_W-1:0] sink_current_level;
   lbsc_host_req_s    host_req;
   lbsc_mcu_req_s     mcu_req;
   lbsc_rsp_s         host_rsp, mcu_rsp;
   int                miscompares = 0, comparisons = 0, n, run, best;

   lbsc_top #(.SLEW_CYCLES(SC)) lbsc_top_i (.ref_clk, .resetn, .host_req, .host_rsp, .mcu_req, .mcu_rsp,
      .global_enable, .duty_request, .converter_on, .current_range_select, .sink_current_level,
      .switching_frequency_select, .slew_busy, .boost_gate);
   lbsc_host_model lbsc_host_model_i (.ref_clk, .host_req, .host_rsp, .mcu_req, .mcu_rsp);

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Comparison and closing report
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic eh);
      lbsc_host_model_i.acc(1'b0, a, 8'h00, q, h);
      chk("read data", e, q);
      chk("read hit", 8'(eh), 8'(h));
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      lbsc_host_model_i.acc(1'b1, a, d, q, h);
   endtask
   // Longest gate-high run over a window of several switching periods
   task automatic gate_run(input logic [7:0] e);
      best = 0;
      run = 0;
      for (int i = 0; i < 500; i++) begin
         @(posedge ref_clk);
         #1;
         run = boost_gate ? run + 1 : 0;
         if (run > best) best = run;
      end
      chk("gate run", e, 8'(best));
   endtask
   // Bounded wait for the ramp to finish
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
      // Busy is looked at off the edge so it is never read as it launches
      for (n = 0; n < 400 && slew_busy !== 1'b0; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n >= 400) begin
         miscompares++;
         end_sim;
      end
   endtask

   initial begin
      resetn = 1'b0;
      global_enable = 1'b0;
      duty_request = 8'hff;
      repeat (8) @(posedge ref_clk);
      #1 resetn = 1'b1;
      rd(16'h0086, OUT_CUR_RST, 1'b1);
      rd(16'ha087, CTRL_RST, 1'b1);
      chk("range", 8'h01, 8'(current_range_select));
      $display("test reset done");
      wr(16'ha087, 8'hff);
      rd(16'ha087, 8'hcf, 1'b1);
      wr(16'ha087, 8'h00);
      rd(16'h0087, 8'h00, 1'b1);
      chk("freq", 8'h00, 8'(switching_frequency_select));
      rd(16'h0186, 8'h00, 1'b0);
      rd(16'ha088, 8'h00, 1'b0);
      wr(16'h0088, 8'h55);
      rd(16'h0086, OUT_CUR_RST, 1'b1);
      $display("test map done");
      // Enable with code and range in one byte, then retarget during the ramp
      global_enable = 1'b1;
      wr(16'h0086, 8'h83);
      wr(16'h0086, 8'h9f);
      rd(16'ha086, 8'h83, 1'b1);
      chk("busy", 8'h01, 8'(slew_busy));
      chk("on", 8'h01, 8'(converter_on));
      chk("range", 8'h00, 8'(current_range_select));
      settle();
      chk("level", 8'h03, 8'(sink_current_level));
      gate_run(8'(PERIOD_SLOW * MAX_DUTY_PCT / 100));
      $display("test ramp done");
      global_enable = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk("on", 8'h00, 8'(converter_on));
      rd(16'h0086, 8'h83, 1'b1);
      global_enable = 1'b1;
      wr(16'h0086, 8'h43);
      rd(16'h0086, 8'h43, 1'b1);
      chk("on", 8'h00, 8'(converter_on));
      chk("range", 8'h01, 8'(current_range_select));
      // Fast clock chosen while off, so no gate run straddles the period change
      wr(16'ha087, 8'hc2);
      wr(16'h0086, 8'hc3);
      chk("freq", 8'h01, 8'(switching_frequency_select));
      gate_run(8'(PERIOD_FAST * MAX_DUTY_PCT / 100));
      chk("on", 8'h01, 8'(converter_on));
      $display("test enable done");
      resetn = 1'b0;
      @(posedge ref_clk);
      #1 resetn = 1'b1;
      rd(16'h0086, OUT_CUR_RST, 1'b1);
      rd(16'ha087, CTRL_RST, 1'b1);
      chk("on", 8'h00, 8'(converter_on));
      $display("test power-on reset done");
      end_sim;
   end
endmodule // led_backlight_sink_control_bench
